// ==== lrx_regs.svh ====
`ifndef LRX_REGS_SVH
`define LRX_REGS_SVH
// Register indices; the byte address is four times the index
`define LRX_IDX_LINK_PAGE 12'h300
`define LRX_IDX_CTRL0 12'h475
`define LRX_IDX_CTRL1 12'h476
`define LRX_IDX_TEST_CTRL 12'h477
`define LRX_IDX_ILAS_LEN 12'h478
`define LRX_IDX_THRESH 12'h47c
`define LRX_IDX_SYNC_MASK 12'h47d
`define LRX_IDX_CFG_FIRST 12'h450
`define LRX_IDX_CFG_LAST 12'h45a
`define LRX_IDX_IRQ_STAT 12'h500
`define LRX_IDX_IRQ_MASK 12'h501
`define LRX_IDX_STATUS 12'h502
// Field positions
`define LRX_SOFT_RESET_BIT 3
`define LRX_QUALIFY_BIT 4
`define LRX_CKSUM_SEL_BIT 0
`define LRX_TEST_MODE_BIT 7
`define LRX_REPEAT_BIT 5
`define LRX_QUEUE_BIT 4
`define LRX_AUTOCLR_BIT 3
// Reset values
`define LRX_CTRL0_RST 8'h00
`define LRX_CTRL1_RST 8'h10
`define LRX_TEST_RST 8'h00
`define LRX_ILAS_RST 8'h01
`define LRX_THRESH_RST 8'hff
`define LRX_MASK_RST 8'h07
// Writable bit masks
`define LRX_CTRL0_WMASK 8'hf8
`define LRX_CTRL1_WMASK 8'h1f
`define LRX_TEST_WMASK 8'hf8
`define LRX_MASK_WMASK 8'h07
// Sync request pulse length in cycles
`define LRX_SYNC_PULSE 4'h4
`endif

// ==== lrx_pkg.sv ====
package lrx_pkg;
  localparam int LANES = 8;
  localparam int LINKS = 2;
  localparam int NCFG = 11;
  typedef logic [7:0] lrx_byte_t;
  typedef enum logic [1:0] {
    LRX_RPT_IDLE = 2'b00,
    LRX_RPT_SYNC = 2'b01,
    LRX_RPT_GAP = 2'b10
  } lrx_rpt_state_t;
endpackage

// ==== lrx_err_if.sv ====
// Carries per-lane error flags and auto-clear requests between modules
interface lrx_err_if;
  logic [lrx_pkg::LANES*3-1:0] hit;
  logic [lrx_pkg::LANES*3-1:0] clr;
  logic trigger;
  modport counter (output hit, input clr, output trigger);
  modport reporter (input hit, output clr, input trigger);
endinterface

// ==== lrx_err_cnt.sv ====
`include "lrx_regs.svh"
// Per-lane, per-type error counters compared against the threshold
module lrx_err_cnt (
  // Clock and reset
  input wire logic aclk,
  input wire logic rst_n,
  // Error strobes: lane*3 + {disparity, not-in-table, unexpected K}
  input wire logic [lrx_pkg::LANES*3-1:0] err_in,
  input wire logic [7:0] threshold,
  input wire logic [2:0] mask,
  // To reporter
  lrx_err_if.counter eif
);
  logic [7:0] cnt_r [lrx_pkg::LANES*3];
  logic [7:0] cnt_nxt [lrx_pkg::LANES*3];
  logic [lrx_pkg::LANES*3-1:0] hit_v;

  // Count, saturate at threshold, clear on request
  always_comb begin
    for (int i = 0; i < lrx_pkg::LANES*3; i++) begin
      cnt_nxt[i] = cnt_r[i];
      if (eif.clr[i]) begin
        cnt_nxt[i] = 8'h00;
      end else if (err_in[i] && cnt_r[i] != threshold) begin
        cnt_nxt[i] = cnt_r[i] + 8'h01;
      end
      hit_v[i] = (cnt_r[i] == threshold) && mask[i % 3];
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < lrx_pkg::LANES*3; i++) begin
      if (!rst_n) cnt_r[i] <= 8'h00;
      else cnt_r[i] <= cnt_nxt[i];
    end
  end

  assign eif.hit = hit_v;
  assign eif.trigger = |hit_v;
endmodule

// ==== lrx_reporter.sv ====
`include "lrx_regs.svh"
// Turns counter hits into sync request pulses when grouped, or pend_in errors into one pulse each when queued
module lrx_reporter (
  // Clock and reset
  input wire logic aclk,
  input wire logic rst_n,
  // Settings
  input wire logic queued,
  input wire logic autoclr,
  input wire logic [7:0] pend_in,
  // From counters
  lrx_err_if.reporter eif,
  // Outputs
  output logic sync_req,
  output logic [7:0] pending
);
  lrx_pkg::lrx_rpt_state_t st_r, st_nxt;
  logic [3:0] tmr_r, tmr_nxt;
  logic [7:0] pend_r, pend_nxt;
  logic [lrx_pkg::LANES*3-1:0] clr_v;
  logic [lrx_pkg::LANES*3-1:0] seen_r, seen_nxt;
  logic [lrx_pkg::LANES*3-1:0] fresh;

  // One pulse per batch of fresh hits seen in idle (hits during a pulse or gap are dropped); queued mode emits one per pending error
  always_comb begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    seen_nxt = eif.hit;
    fresh = eif.hit & ~seen_r;
    pend_nxt = pend_r;
    clr_v = '0;
    if (queued) begin
      pend_nxt = pend_r + pend_in;
    end
    if (autoclr) begin
      clr_v = fresh;
    end
    unique case (st_r)
      lrx_pkg::LRX_RPT_IDLE: begin
        if (queued && pend_r != 8'h00) begin
          pend_nxt = pend_r - 8'h01 + pend_in;
          st_nxt = lrx_pkg::LRX_RPT_SYNC;
          tmr_nxt = `LRX_SYNC_PULSE;
        end else if (!queued && |fresh) begin
          st_nxt = lrx_pkg::LRX_RPT_SYNC;
          tmr_nxt = `LRX_SYNC_PULSE;
        end
      end
      lrx_pkg::LRX_RPT_SYNC: begin
        tmr_nxt = tmr_r - 4'h1;
        if (tmr_r == 4'h1) begin
          st_nxt = lrx_pkg::LRX_RPT_GAP;
          tmr_nxt = `LRX_SYNC_PULSE;
        end
      end
      lrx_pkg::LRX_RPT_GAP: begin
        tmr_nxt = tmr_r - 4'h1;
        if (tmr_r == 4'h1) st_nxt = lrx_pkg::LRX_RPT_IDLE;
      end
      default: st_nxt = lrx_pkg::LRX_RPT_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!rst_n) begin
      st_r <= lrx_pkg::LRX_RPT_IDLE;
      tmr_r <= 4'h0;
      pend_r <= 8'h00;
      seen_r <= '0;
    end else begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      pend_r <= pend_nxt;
      seen_r <= seen_nxt;
    end
  end

  assign eif.clr = clr_v;
  assign sync_req = (st_r == lrx_pkg::LRX_RPT_SYNC);
  assign pending = pend_r;
endmodule

// ==== lrx_link_ctrl.sv ====
// Added by the designer: the AXI4-Lite register port.
`include "lrx_regs.svh"
module lrx_link_ctrl (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Lane decoder errors, per link: lane*3 + {disparity, not-in-table, unexpected K}
  input wire logic [lrx_pkg::LANES*3-1:0] lane_err_l0,
  input wire logic [lrx_pkg::LANES*3-1:0] lane_err_l1,
  // Repeat-pattern mismatch strobe per link and lane
  input wire logic [lrx_pkg::LANES-1:0] pat_mismatch_l0,
  input wire logic [lrx_pkg::LANES-1:0] pat_mismatch_l1,
  // Link-side controls
  output logic [lrx_pkg::LINKS-1:0] link_test_mode,
  output logic [lrx_pkg::LINKS-1:0] pattern_check_en,
  output logic [lrx_pkg::LINKS-1:0] link_soft_reset,
  output logic [9:0] ilas_frames_l0,
  output logic [9:0] ilas_frames_l1,
  output logic [7:0] expected_cksum_l0,
  output logic [7:0] expected_cksum_l1,
  output logic [lrx_pkg::LINKS-1:0] sync_request_out,
  output logic irq
);
  // Register copies per link
  lrx_pkg::lrx_byte_t ctrl0_r [lrx_pkg::LINKS];
  lrx_pkg::lrx_byte_t ctrl1_r [lrx_pkg::LINKS];
  lrx_pkg::lrx_byte_t test_r [lrx_pkg::LINKS];
  lrx_pkg::lrx_byte_t ilas_r [lrx_pkg::LINKS];
  lrx_pkg::lrx_byte_t thr_r [lrx_pkg::LINKS];
  lrx_pkg::lrx_byte_t msk_r [lrx_pkg::LINKS];
  lrx_pkg::lrx_byte_t cfg_r [lrx_pkg::LINKS][lrx_pkg::NCFG];
  logic page_r;
  logic [3:0] ist_r, ist_nxt, imsk_r;
  logic [lrx_pkg::LINKS-1:0] sync_d_r;
  // Bus handshake state
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic awready_r, wready_r, arready_r;
  logic [11:0] aw_idx_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  logic do_wr, wr_hit;
  logic [lrx_pkg::LINKS-1:0] sync_w;
  logic [7:0] pend_w [lrx_pkg::LINKS];
  logic [lrx_pkg::LANES*3-1:0] err_q [lrx_pkg::LINKS];
  logic [lrx_pkg::LANES*3-1:0] err_raw [lrx_pkg::LINKS];
  logic [lrx_pkg::LANES-1:0] mis_raw [lrx_pkg::LINKS];
  logic [7:0] cks [lrx_pkg::LINKS];
  logic [lrx_pkg::LINKS-1:0] lrst_n;

  // Checksum of configuration bytes, either method
  function automatic logic [7:0] calc_cksum(input lrx_pkg::lrx_byte_t b [lrx_pkg::NCFG], input logic packed_m);
    logic [7:0] s;
    s = 8'h00;
    if (packed_m) begin
      for (int k = 0; k < lrx_pkg::NCFG; k++) s = s + b[k];
    end else begin
      // Individual fields: DID, BID, LID, SCR, L, F, K, M, N, CS, N', S, JESDV, CF, HD, SUBCLASS
      s = b[0] + {4'h0, b[1][3:0]} + {3'h0, b[2][4:0]} + {7'h00, b[3][7]} + {3'h0, b[3][4:0]};
      s = s + b[4] + {3'h0, b[5][4:0]} + b[6] + {3'h0, b[7][4:0]} + {6'h00, b[7][7:6]};
      s = s + {3'h0, b[8][4:0]} + {5'h00, b[8][7:5]} + {3'h0, b[9][4:0]} + {5'h00, b[9][7:5]};
      s = s + {3'h0, b[10][4:0]} + {7'h00, b[10][7]};
    end
    return s;
  endfunction

  // Error qualification and pattern errors feed the counters
  always_comb begin
    err_raw[0] = lane_err_l0;
    err_raw[1] = lane_err_l1;
    mis_raw[0] = pat_mismatch_l0;
    mis_raw[1] = pat_mismatch_l1;
    for (int l = 0; l < lrx_pkg::LINKS; l++) begin
      err_q[l] = err_raw[l];
      for (int n = 0; n < lrx_pkg::LANES; n++) begin
        if (ctrl1_r[l][`LRX_QUALIFY_BIT] && err_raw[l][n*3+1]) err_q[l][n*3+2] = 1'b0;
        if (test_r[l][`LRX_REPEAT_BIT] && !test_r[l][`LRX_TEST_MODE_BIT] && mis_raw[l][n])
          err_q[l][n*3+2] = 1'b1;
      end
      lrst_n[l] = aresetn && !ctrl0_r[l][`LRX_SOFT_RESET_BIT];
      cks[l] = calc_cksum(cfg_r[l], ctrl1_r[l][`LRX_CKSUM_SEL_BIT]);
    end
  end

  // Counter and reporter per link
  for (genvar g = 0; g < lrx_pkg::LINKS; g++) begin : g_link
    lrx_err_if eif();
    logic qmode;
    logic [7:0] pin;
    assign qmode = test_r[g][`LRX_QUEUE_BIT] && test_r[g][`LRX_REPEAT_BIT];
    assign pin = qmode ? 8'($countones(mis_raw[g])) : 8'h00;
    lrx_err_cnt u_cnt (
      .aclk(aclk),
      .rst_n(lrst_n[g]),
      .err_in(err_q[g]),
      .threshold(thr_r[g]),
      .mask(msk_r[g][2:0]),
      .eif(eif)
    );
    lrx_reporter u_rpt (
      .aclk(aclk),
      .rst_n(lrst_n[g]),
      .queued(qmode),
      .autoclr(test_r[g][`LRX_AUTOCLR_BIT]),
      .pend_in(pin),
      .eif(eif),
      .sync_req(sync_w[g]),
      .pending(pend_w[g])
    );
  end

  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_hit = (aw_idx_r == `LRX_IDX_LINK_PAGE) || (aw_idx_r == `LRX_IDX_CTRL0)
    || (aw_idx_r == `LRX_IDX_CTRL1) || (aw_idx_r == `LRX_IDX_TEST_CTRL) || (aw_idx_r == `LRX_IDX_ILAS_LEN)
    || (aw_idx_r == `LRX_IDX_THRESH) || (aw_idx_r == `LRX_IDX_SYNC_MASK) || (aw_idx_r == `LRX_IDX_IRQ_STAT)
    || (aw_idx_r == `LRX_IDX_IRQ_MASK)
    || (aw_idx_r >= `LRX_IDX_CFG_FIRST && aw_idx_r <= `LRX_IDX_CFG_LAST);

  // Interrupt status: sync request rising edge per link, pending nonzero per link; set wins
  always_comb begin
    ist_nxt = ist_r;
    if (do_wr && aw_idx_r == `LRX_IDX_IRQ_STAT && wstrb_r[0]) ist_nxt = ist_r & ~wdata_r[3:0];
    ist_nxt = ist_nxt | {pend_w[1] != 8'h00, pend_w[0] != 8'h00, sync_w & ~sync_d_r};
  end

  // Bus channels and register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
      aw_idx_r <= 12'h000;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      page_r <= 1'b0;
      ist_r <= 4'h0;
      imsk_r <= 4'h0;
      sync_d_r <= '0;
      for (int l = 0; l < lrx_pkg::LINKS; l++) begin
        ctrl0_r[l] <= `LRX_CTRL0_RST;
        ctrl1_r[l] <= `LRX_CTRL1_RST;
        test_r[l] <= `LRX_TEST_RST;
        ilas_r[l] <= `LRX_ILAS_RST;
        thr_r[l] <= `LRX_THRESH_RST;
        msk_r[l] <= `LRX_MASK_RST;
        for (int k = 0; k < lrx_pkg::NCFG; k++) cfg_r[l][k] <= 8'h00;
      end
    end else begin
      sync_d_r <= sync_w;
      ist_r <= ist_nxt;
      if (s_axi_awvalid && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        awready_r <= 1'b0;
        aw_idx_r <= s_axi_awaddr[13:2];
      end
      if (s_axi_wvalid && !w_hold_r) begin
        w_hold_r <= 1'b1;
        wready_r <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? 2'b00 : 2'b10;
        if (wstrb_r[0]) begin
          // Link settings reach the copy of the paged link only; the page and interrupt mask are shared
          unique case (aw_idx_r)
            `LRX_IDX_LINK_PAGE: page_r <= wdata_r[0];
            `LRX_IDX_CTRL0: ctrl0_r[page_r] <= wdata_r[7:0] & `LRX_CTRL0_WMASK;
            `LRX_IDX_CTRL1: ctrl1_r[page_r] <= wdata_r[7:0] & `LRX_CTRL1_WMASK;
            `LRX_IDX_TEST_CTRL: test_r[page_r] <= wdata_r[7:0] & `LRX_TEST_WMASK;
            `LRX_IDX_ILAS_LEN: ilas_r[page_r] <= wdata_r[7:0];
            `LRX_IDX_THRESH: thr_r[page_r] <= wdata_r[7:0];
            `LRX_IDX_SYNC_MASK: msk_r[page_r] <= wdata_r[7:0] & `LRX_MASK_WMASK;
            `LRX_IDX_IRQ_MASK: imsk_r <= wdata_r[3:0];
            default: begin
              if (aw_idx_r >= `LRX_IDX_CFG_FIRST && aw_idx_r <= `LRX_IDX_CFG_LAST)
                cfg_r[page_r][4'(aw_idx_r - `LRX_IDX_CFG_FIRST)] <= wdata_r[7:0];
            end
          endcase
        end
      end
      if (bvalid_r && s_axi_bready) bvalid_r <= 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
      rdata_r <= 32'h0;
      rresp_r <= 2'b00;
    end else if (rvalid_r) begin
      if (s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end else if (s_axi_arvalid) begin
      rvalid_r <= 1'b1;
      arready_r <= 1'b0;
      rresp_r <= 2'b00;
      rdata_r <= 32'h0;
      unique case (s_axi_araddr[13:2])
        `LRX_IDX_LINK_PAGE: rdata_r <= {31'h0, page_r};
        `LRX_IDX_CTRL0: rdata_r <= {24'h0, ctrl0_r[page_r]};
        `LRX_IDX_CTRL1: rdata_r <= {24'h0, ctrl1_r[page_r]};
        `LRX_IDX_TEST_CTRL: rdata_r <= {24'h0, test_r[page_r]};
        `LRX_IDX_ILAS_LEN: rdata_r <= {24'h0, ilas_r[page_r]};
        `LRX_IDX_THRESH: rdata_r <= {24'h0, thr_r[page_r]};
        `LRX_IDX_SYNC_MASK: rdata_r <= {24'h0, msk_r[page_r]};
        `LRX_IDX_IRQ_STAT: rdata_r <= {28'h0, ist_r};
        `LRX_IDX_IRQ_MASK: rdata_r <= {28'h0, imsk_r};
        `LRX_IDX_STATUS: rdata_r <= {16'h0, pend_w[page_r], cks[page_r]};
        default: begin
          if (s_axi_araddr[13:2] >= `LRX_IDX_CFG_FIRST && s_axi_araddr[13:2] <= `LRX_IDX_CFG_LAST)
            rdata_r <= {24'h0, cfg_r[page_r][4'(s_axi_araddr[13:2] - `LRX_IDX_CFG_FIRST)]};
          else
            rresp_r <= 2'b10;
        end
      endcase
    end
  end

  // Registered link-side outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_test_mode <= '0;
      pattern_check_en <= '0;
      link_soft_reset <= '0;
      ilas_frames_l0 <= {`LRX_ILAS_RST, 2'b00};
      ilas_frames_l1 <= {`LRX_ILAS_RST, 2'b00};
      expected_cksum_l0 <= 8'h00;
      expected_cksum_l1 <= 8'h00;
      sync_request_out <= '0;
      irq <= 1'b0;
    end else begin
      for (int l = 0; l < lrx_pkg::LINKS; l++) begin
        link_test_mode[l] <= test_r[l][`LRX_TEST_MODE_BIT];
        pattern_check_en[l] <= test_r[l][`LRX_REPEAT_BIT] && !test_r[l][`LRX_TEST_MODE_BIT];
        link_soft_reset[l] <= ctrl0_r[l][`LRX_SOFT_RESET_BIT];
      end
      ilas_frames_l0 <= {ilas_r[0], 2'b00};
      ilas_frames_l1 <= {ilas_r[1], 2'b00};
      expected_cksum_l0 <= cks[0];
      expected_cksum_l1 <= cks[1];
      sync_request_out <= sync_w;
      irq <= |(ist_nxt & imsk_r);
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule

// ==== lrx_link_ctrl_chk.sv ====
// Watches the link control block from its ports only
module lrx_link_ctrl_chk (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link side
  input wire logic [lrx_pkg::LINKS-1:0] link_test_mode,
  input wire logic [lrx_pkg::LINKS-1:0] pattern_check_en,
  input wire logic [lrx_pkg::LINKS-1:0] link_soft_reset,
  input wire logic [9:0] ilas_frames_l0,
  input wire logic [lrx_pkg::LINKS-1:0] sync_request_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Sync events are four-cycle pulses followed by a four-cycle gap
  a_sync_pulse_len: assert property ($rose(sync_request_out[0]) |-> sync_request_out[0][*4] ##1 !sync_request_out[0])
    else $error("sync pulse length wrong");
  a_sync_gap_len: assert property ($fell(sync_request_out[0]) |-> !sync_request_out[0][*4])
    else $error("sync gap too short");
  // Held soft reset keeps the reporter quiet
  a_soft_rst_quiet: assert property (link_soft_reset[0] && $past(link_soft_reset[0]) && $past(link_soft_reset[0], 2)
    |-> !sync_request_out[0])
    else $error("sync request during soft reset");
  a_pattern_excl: assert property ((pattern_check_en & link_test_mode) == '0)
    else $error("pattern check with test mode");
  a_ilas_mult: assert property (ilas_frames_l0[1:0] == 2'b00 && ilas_frames_l0 != 10'h000)
    else $error("ilas length not a multiple of four");
  // One response per request
  a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  // Main scenarios
  c_sync: cover property ($rose(sync_request_out[0]));
  c_pat: cover property ($rose(pattern_check_en[1]));
  c_srst: cover property ($fell(link_soft_reset[0]));
endmodule
bind lrx_link_ctrl lrx_link_ctrl_chk u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .link_test_mode(link_test_mode),
  .pattern_check_en(pattern_check_en), .link_soft_reset(link_soft_reset),
  .ilas_frames_l0(ilas_frames_l0), .sync_request_out(sync_request_out));

// ==== lrx_tx_model.sv ====
// Transmitter side: lane decoder errors and pattern mismatches seen by the receiver
module lrx_tx_model (
  // Clock
  input wire logic aclk,
  // Link state
  input wire logic [lrx_pkg::LINKS-1:0] link_test_mode,
  // Error strobes
  output logic [lrx_pkg::LANES*3-1:0] lane_err_l0,
  output logic [lrx_pkg::LANES*3-1:0] lane_err_l1,
  output logic [lrx_pkg::LANES-1:0] pat_mismatch_l0,
  output logic [lrx_pkg::LANES-1:0] pat_mismatch_l1
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clean link at time zero
  initial begin
    lane_err_l0 = '0;
    lane_err_l1 = '0;
    pat_mismatch_l0 = '0;
    pat_mismatch_l1 = '0;
  end
  // One cycle of errors on one link
  task automatic send(input int link, input logic [lrx_pkg::LANES*3-1:0] e, input logic [lrx_pkg::LANES-1:0] p);
    logic [lrx_pkg::LANES-1:0] q;
    @(posedge aclk);
    // A perpetual ILAS carries no user pattern to mismatch
    q = link_test_mode[link] ? '0 : p;
    if (link == 0) begin
      lane_err_l0 <= e;
      pat_mismatch_l0 <= q;
    end else begin
      lane_err_l1 <= e;
      pat_mismatch_l1 <= q;
    end
    @(posedge aclk);
    lane_err_l0 <= '0;
    lane_err_l1 <= '0;
    pat_mismatch_l0 <= '0;
    pat_mismatch_l1 <= '0;
  endtask
endmodule

// ==== tb.sv ====
// Register and sync request tests for the link control block
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, wresp, rresp_q;
  logic [lrx_pkg::LANES*3-1:0] lane_err_l0, lane_err_l1;
  logic [lrx_pkg::LANES-1:0] pat_mismatch_l0, pat_mismatch_l1;
  logic [lrx_pkg::LINKS-1:0] link_test_mode, pattern_check_en, link_soft_reset, sync_request_out, s_q = '0;
  logic [9:0] ilas_frames_l0, ilas_frames_l1;
  logic [7:0] expected_cksum_l0, expected_cksum_l1;
  logic [7:0] cfg [11] = '{8'h01, 8'hf2, 8'h00, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  int miscompares = 0, check_count = 0, cycles = 0, p0 = 0, base = 0;
  lrx_link_ctrl uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .lane_err_l0(lane_err_l0), .lane_err_l1(lane_err_l1),
    .pat_mismatch_l0(pat_mismatch_l0), .pat_mismatch_l1(pat_mismatch_l1),
    .link_test_mode(link_test_mode), .pattern_check_en(pattern_check_en), .link_soft_reset(link_soft_reset),
    .ilas_frames_l0(ilas_frames_l0), .ilas_frames_l1(ilas_frames_l1),
    .expected_cksum_l0(expected_cksum_l0), .expected_cksum_l1(expected_cksum_l1),
    .sync_request_out(sync_request_out), .irq(irq));
  lrx_tx_model tx (.aclk(aclk), .link_test_mode(link_test_mode), .lane_err_l0(lane_err_l0),
    .lane_err_l1(lane_err_l1), .pat_mismatch_l0(pat_mismatch_l0), .pat_mismatch_l1(pat_mismatch_l1));
  // 50 MHz clock
  always #10 aclk = ~aclk;
  // Counts sync events on link 0 and cuts a hang short
  always @(posedge aclk) begin
    s_q <= sync_request_out;
    if (sync_request_out[0] === 1'b1 && s_q[0] !== 1'b1) p0 <= p0 + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test;
    $display("Checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Write one register word; address and data are released as each is taken
  task automatic wr_reg(input logic [11:0] idx, input logic [7:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    wresp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Read one register word
  task automatic rd_reg(input logic [11:0] idx);
    @(posedge aclk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    rdat = s_axi_rdata;
    rresp_q = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [11:0] idx, input logic [31:0] exp);
    rd_reg(idx);
    chk(what, exp, rdat);
  endtask
  // Soft reset of the paged link
  task automatic srst(input logic on);
    wr_reg(12'h475, {4'h0, on, 3'h0});
  endtask
  // Errors on link 0, then the count of sync events since the base
  task automatic hit(input logic [23:0] e, input logic [7:0] p, input int n);
    tx.send(0, e, p);
    idle(40);
    chk("sync_events", n, p0 - base);
  endtask
  // Main sequence
  initial begin
    idle(6);
    aresetn <= 1'b1;
    rchk("test_rst", 12'h477, 32'h00);
    rchk("ilas_rst", 12'h478, 32'h01);
    rchk("ctrl1_rst", 12'h476, 32'h10);
    chk("ilas_out_rst", 32'h004, ilas_frames_l0);
    rchk("unmapped", 12'h001, 32'h0);
    chk("rresp", 32'h2, rresp_q);
    wr_reg(12'h001, 8'h55);
    chk("bresp", 32'h2, wresp);
    for (int l = 0; l < 2; l++) begin
      wr_reg(12'h300, 8'(l));
      srst(1'b1);
    end
    wr_reg(12'h478, 8'h02);
    wr_reg(12'h477, 8'hff);
    rchk("test_mixed", 12'h477, 32'hf8);
    idle(3);
    chk("test_mode", 32'h1, link_test_mode[1]);
    chk("pat_en_off", 32'h0, pattern_check_en[1]);
    chk("soft_rst", 32'h3, link_soft_reset);
    wr_reg(12'h477, 8'h20);
    idle(3);
    chk("pat_en_on", 32'h1, pattern_check_en[1]);
    wr_reg(12'h300, 8'h00);
    wr_reg(12'h478, 8'hff);
    idle(3);
    chk("ilas0", 32'h3fc, ilas_frames_l0);
    chk("ilas1", 32'h008, ilas_frames_l1);
    rchk("ilas_page0", 12'h478, 32'hff);
    for (int i = 0; i < 11; i++) wr_reg(12'h450 + 12'(i), cfg[i]);
    wr_reg(12'h476, 8'h11);
    idle(3);
    chk("cksum_bytes", 32'h74, expected_cksum_l0);
    chk("cksum_l1", 32'h00, expected_cksum_l1);
    rchk("status_cksum", 12'h502, 32'h74);
    wr_reg(12'h476, 8'h10);
    idle(3);
    chk("cksum_fields", 32'h05, expected_cksum_l0);
    wr_reg(12'h47c, 8'h01);
    wr_reg(12'h501, 8'h00);
    base = p0;
    hit(24'h000002, 8'h00, 0);
    srst(1'b0);
    hit(24'h000012, 8'h00, 1);
    chk("irq_masked", 32'h0, irq);
    rchk("irq_stat", 12'h500, 32'h01);
    wr_reg(12'h501, 8'h01);
    idle(2);
    chk("irq_on", 32'h1, irq);
    wr_reg(12'h500, 8'h01);
    idle(2);
    chk("irq_clr", 32'h0, irq);
    srst(1'b1);
    wr_reg(12'h47d, 8'h04);
    srst(1'b0);
    hit(24'h000006, 8'h00, 1);
    srst(1'b1);
    wr_reg(12'h476, 8'h00);
    srst(1'b0);
    hit(24'h000006, 8'h00, 2);
    srst(1'b1);
    wr_reg(12'h47d, 8'h07);
    wr_reg(12'h47c, 8'h02);
    wr_reg(12'h477, 8'h08);
    srst(1'b0);
    hit(24'h000002, 8'h00, 2);
    hit(24'h000010, 8'h00, 2);
    hit(24'h000002, 8'h00, 3);
    hit(24'h000010, 8'h00, 4);
    hit(24'h000002, 8'h00, 4);
    srst(1'b1);
    wr_reg(12'h477, 8'h30);
    srst(1'b0);
    hit(24'h000000, 8'h07, 7);
    stop_test();
  end
endmodule
